// File: core/cfg_init_pkg.sv
package cfg_init_pkg;

  // Clocking
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 10_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV - 1);

  // Initialization and error recovery timing
  localparam int INIT_CYCLES = 3185;
  localparam logic [11:0] INIT_LAST = 12'(INIT_CYCLES - 1);
  localparam int RESET_TIMEOUT_NS = 40_000;
  localparam int TIMEOUT_CYC = (RESET_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] TIMEOUT_LAST = 12'(TIMEOUT_CYC - 1);

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LENGTH = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [15:0] LENGTH_RST = 16'h0100;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Escape byte of the compressed stream: next byte is a zero-run length minus one
  localparam logic [7:0] ESC_BYTE = 8'h00;

  typedef struct packed {
    logic [25:0] rsvd;
    logic user_io_drive;
    logic user_io_out;
    logic compress_en;
    logic auto_restart;
    logic init_done_en;
    logic ext_clk_sel;
  } ctrl_t;

  typedef struct packed {
    logic cfg_error;
    logic user_mode;
    logic load_done;
  } irq_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } cfg_beat_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } seq_state_t;

endpackage : cfg_init_pkg

// File: core/config_init_sequencer.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps

// Operation
// - Initialization clock defaults to the internal 10 MHz oscillator tick.
// - A control bit picks internal oscillator or external startup clock pin.
// - External startup clock only drives initialization counting, never the load.
// - After load complete, count 3185 initialization clocks, then enter user mode.
// - Without external clock selected, startup clock pin is plain user I/O.
// - Init-complete pin makes one low-to-high step at start of user mode.
// - Init-complete pin is optional, open-drain: pulled low or released.
// - On error with auto-restart, pull status pin low and reset internally.
// - After reset time-out, release the status pin so pull-up raises it.
// - Compressed stream is expanded on the fly while loading.
module config_init_sequencer
  import cfg_init_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq,
  // Configuration stream in
  input wire logic cfg_valid,
  input wire cfg_beat_t cfg_beat,
  output logic cfg_ready,
  // Expanded configuration bytes out
  output logic out_valid,
  output logic [7:0] out_data,
  // Sequencer state
  output logic load_complete_flag,
  output logic user_mode,
  input wire logic restart_req,
  // Startup clock pin
  input wire logic user_startup_clock_pin_i,
  output logic user_startup_clock_pin_o,
  output logic user_startup_clock_pin_oe_b,
  // Init-complete pin
  output logic init_done_pin_o,
  output logic init_done_pin_oe_b,
  // Status pin
  input wire logic config_error_status_pin_i,
  output logic config_error_status_pin_o,
  output logic config_error_status_pin_oe_b
);

  // Bus group
  ctrl_t ctrl_ff, nxt_ctrl;
  logic [15:0] length_ff, nxt_length;
  irq_t irq_stat_ff, nxt_irq_stat;
  irq_t irq_mask_ff, nxt_irq_mask;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;

  // Sequencer group
  seq_state_t st_ff, nxt_st;
  logic [15:0] byte_cnt_ff, nxt_byte_cnt;
  logic [7:0] run_cnt_ff, nxt_run_cnt;
  logic esc_pend_ff, nxt_esc_pend;
  logic last_pend_ff, nxt_last_pend;
  logic [11:0] init_cnt_ff, nxt_init_cnt;
  logic [11:0] tmo_cnt_ff, nxt_tmo_cnt;
  logic [2:0] osc_cnt_ff, nxt_osc_cnt;
  logic ext_prev_ff, nxt_ext_prev;
  logic oval_ff, nxt_oval;
  logic [7:0] odata_ff, nxt_odata;

  logic [31:0] wmask;
  logic bus_wr;
  logic [31:0] count_word;
  logic [31:0] status_word;
  logic osc_tick;
  logic ext_tick;
  logic init_tick;
  logic accept;
  irq_t ev;

  // Byte-lane write mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  // Write strobe and read-only views
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign count_word = {init_cnt_ff, 4'h0, byte_cnt_ff};
  assign status_word = {27'h0, config_error_status_pin_i, user_startup_clock_pin_i, st_ff};

  // Register access; writes land on the edge where ack is seen
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_length = length_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rdata = 32'h0000_0000;
    if (bus_wr) begin
      if (wb_adr_i == ADDR_CTRL) begin
        nxt_ctrl = (ctrl_ff & ~wmask) | (wb_dat_i & wmask);
        nxt_ctrl.rsvd = '0;
      end else if (wb_adr_i == ADDR_LENGTH) begin
        nxt_length = (length_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == ADDR_IRQ_MASK) begin
        nxt_irq_mask = (irq_mask_ff & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
      end else if (wb_adr_i == ADDR_IRQ_STAT) begin
        nxt_irq_stat = irq_stat_ff & ~(wb_dat_i[2:0] & wmask[2:0]);
      end
    end
    // Hardware set wins over a clear in the same cycle
    nxt_irq_stat = nxt_irq_stat | ev;
    if (nxt_ack & ~wb_we_i) begin
      if (wb_adr_i == ADDR_CTRL) begin
        nxt_rdata = ctrl_ff;
      end else if (wb_adr_i == ADDR_STATUS) begin
        nxt_rdata = status_word;
      end else if (wb_adr_i == ADDR_LENGTH) begin
        nxt_rdata = {16'h0000, length_ff};
      end else if (wb_adr_i == ADDR_COUNT) begin
        nxt_rdata = count_word;
      end else if (wb_adr_i == ADDR_IRQ_STAT) begin
        nxt_rdata = {29'h0, irq_stat_ff};
      end else if (wb_adr_i == ADDR_IRQ_MASK) begin
        nxt_rdata = {29'h0, irq_mask_ff};
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RST;
      length_ff <= LENGTH_RST;
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      length_ff <= nxt_length;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  // Level interrupt from unmasked sticky bits
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Initialization clock sources
  assign osc_tick = (osc_cnt_ff == OSC_DIV_LAST);
  // Rising edge of the startup pin
  assign ext_tick = user_startup_clock_pin_i & ~ext_prev_ff;
  assign init_tick = ctrl_ff.ext_clk_sel ? ext_tick : osc_tick;

  // Stream is taken only while loading and no zero run is pending
  assign accept = cfg_valid & cfg_ready;
  assign cfg_ready = (st_ff == ST_LOAD) & (run_cnt_ff == 8'h00) & ~last_pend_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_run_cnt = run_cnt_ff;
    nxt_esc_pend = esc_pend_ff;
    nxt_last_pend = last_pend_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_tmo_cnt = tmo_cnt_ff;
    nxt_osc_cnt = osc_tick ? 3'h0 : 3'(osc_cnt_ff + 3'h1);
    nxt_ext_prev = user_startup_clock_pin_i;
    nxt_oval = 1'b0;
    nxt_odata = odata_ff;
    ev = '0;
    case (st_ff)
      ST_IDLE: begin
        // Internal reset of load and init state
        nxt_byte_cnt = 16'h0000;
        nxt_run_cnt = 8'h00;
        nxt_esc_pend = 1'b0;
        nxt_last_pend = 1'b0;
        nxt_init_cnt = 12'h000;
        nxt_tmo_cnt = 12'h000;
        if (config_error_status_pin_i) begin
          nxt_st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Pending zero run goes out first, one byte a cycle
        if (run_cnt_ff != 8'h00) begin
          nxt_oval = 1'b1;
          nxt_odata = 8'h00;
          nxt_run_cnt = 8'(run_cnt_ff - 8'h01);
        end else if (accept) begin
          nxt_last_pend = cfg_beat.last;
          if (esc_pend_ff) begin
            nxt_oval = 1'b1;
            nxt_odata = 8'h00;
            nxt_run_cnt = cfg_beat.data;
            nxt_esc_pend = 1'b0;
          end else if (ctrl_ff.compress_en && cfg_beat.data == ESC_BYTE) begin
            nxt_esc_pend = 1'b1;
          end else begin
            nxt_oval = 1'b1;
            nxt_odata = cfg_beat.data;
          end
        end else if (last_pend_ff) begin
          nxt_st = ST_ERROR; // Stream ended short of the length
          ev.cfg_error = 1'b1;
        end
        // Expanded byte count ends the load
        if (nxt_oval) begin
          nxt_byte_cnt = 16'(byte_cnt_ff + 16'h0001);
          if (nxt_byte_cnt == length_ff) begin
            nxt_st = ST_INIT;
            ev.load_done = 1'b1;
          end
        end
      end
      ST_INIT: begin
        if (init_tick) begin
          nxt_init_cnt = 12'(init_cnt_ff + 12'h001);
          if (init_cnt_ff == INIT_LAST) begin
            nxt_st = ST_USER;
            ev.user_mode = 1'b1;
          end
        end
      end
      ST_USER: begin
        nxt_st = ST_USER;
      end
      ST_ERROR: begin
        // Time-out runs only with auto-restart
        if (ctrl_ff.auto_restart) begin
          nxt_tmo_cnt = 12'(tmo_cnt_ff + 12'h001);
          if (tmo_cnt_ff == TIMEOUT_LAST) begin
            nxt_st = ST_IDLE;
          end
        end else if (restart_req) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= ST_IDLE;
      byte_cnt_ff <= 16'h0000;
      run_cnt_ff <= 8'h00;
      esc_pend_ff <= 1'b0;
      last_pend_ff <= 1'b0;
      init_cnt_ff <= 12'h000;
      tmo_cnt_ff <= 12'h000;
      osc_cnt_ff <= 3'h0;
      ext_prev_ff <= 1'b0;
      oval_ff <= 1'b0;
      odata_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      byte_cnt_ff <= nxt_byte_cnt;
      run_cnt_ff <= nxt_run_cnt;
      esc_pend_ff <= nxt_esc_pend;
      last_pend_ff <= nxt_last_pend;
      init_cnt_ff <= nxt_init_cnt;
      tmo_cnt_ff <= nxt_tmo_cnt;
      osc_cnt_ff <= nxt_osc_cnt;
      ext_prev_ff <= nxt_ext_prev;
      oval_ff <= nxt_oval;
      odata_ff <= nxt_odata;
    end
  end

  // Expanded bytes and state flags
  assign out_valid = oval_ff;
  assign out_data = odata_ff;
  assign load_complete_flag = (st_ff == ST_INIT) | (st_ff == ST_USER);
  assign user_mode = (st_ff == ST_USER);

  // Pins
  // Open-drain init-complete and status pins: output tied low, only the enable moves
  assign user_startup_clock_pin_o = ~ctrl_ff.ext_clk_sel & ctrl_ff.user_io_out;
  assign user_startup_clock_pin_oe_b = ctrl_ff.ext_clk_sel | ~ctrl_ff.user_io_drive;
  assign init_done_pin_o = 1'b0;
  assign init_done_pin_oe_b = ~ctrl_ff.init_done_en | (st_ff == ST_USER);
  assign config_error_status_pin_o = 1'b0;
  assign config_error_status_pin_oe_b = (st_ff != ST_ERROR);

endmodule : config_init_sequencer

// File: verif/cfg_init_asserts.sv
`timescale 1ns/1ps
module cfg_init_asserts
  import cfg_init_pkg::*;
(
  // Clock and bus
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Sequencer and pins
  input wire logic cfg_ready,
  input wire logic out_valid,
  input wire logic load_complete_flag,
  input wire logic user_mode,
  input wire logic init_done_pin_o,
  input wire logic init_done_pin_oe_b,
  input wire logic config_error_status_pin_o,
  input wire logic config_error_status_pin_oe_b
);
  logic [15:0] init_cnt_ff;
  logic [15:0] nxt_init_cnt;
  // Cycles since load complete, through initialization and user mode, saturating
  always_comb begin
    nxt_init_cnt = init_cnt_ff;
    if (!load_complete_flag) nxt_init_cnt = '0;
    else if (init_cnt_ff != 16'hffff) nxt_init_cnt = 16'(init_cnt_ff + 16'h0001);
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) init_cnt_ff <= '0;
    else init_cnt_ff <= nxt_init_cnt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack not a single cycle pulse");
  property p_um_hold; user_mode |=> user_mode; endproperty
  a_um_hold: assert property (p_um_hold) else $error("user mode left");
  property p_um_lcf; user_mode |-> load_complete_flag; endproperty
  a_um_lcf: assert property (p_um_lcf) else $error("user mode without load");
  property p_um_cnt; $rose(user_mode) |-> init_cnt_ff >= 16'(INIT_LAST); endproperty
  a_um_cnt: assert property (p_um_cnt) else $error("user mode too early");
  property p_init_pin; user_mode |-> init_done_pin_oe_b; endproperty
  a_init_pin: assert property (p_init_pin) else $error("init pin held low in user mode");
  property p_od; !init_done_pin_o && !config_error_status_pin_o; endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  property p_err; !config_error_status_pin_oe_b |-> !load_complete_flag && !cfg_ready; endproperty
  a_err: assert property (p_err) else $error("error state still loading");
  property p_hold; $fell(config_error_status_pin_oe_b) |-> !config_error_status_pin_oe_b [*8]; endproperty
  a_hold: assert property (p_hold) else $error("status pin released early");
  property p_out; out_valid |-> !user_mode; endproperty
  a_out: assert property (p_out) else $error("bytes out in user mode");
  c_user: cover property ($rose(user_mode));
  c_err: cover property ($fell(config_error_status_pin_oe_b));
  c_out: cover property (out_valid);
endmodule : cfg_init_asserts

// File: verif/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model
  import cfg_init_pkg::*;
(
  // Clock and device state
  input wire logic clk_sys,
  input wire logic cfg_ready,
  input wire logic status_pin,
  // Stream and startup clock
  output logic cfg_valid,
  output cfg_beat_t cfg_beat,
  output logic ext_clk
);
  initial begin
    cfg_valid = 1'b0;
    cfg_beat = '0;
    ext_clk = 1'b0;
  end
  task automatic send(input logic [7:0] d, input logic l);
    wait (status_pin === 1'b1);
    @(posedge clk_sys);
    cfg_valid <= 1'b1;
    cfg_beat <= '{data: d, last: l};
    do @(posedge clk_sys); while (cfg_ready !== 1'b1);
    cfg_valid <= 1'b0;
    cfg_beat <= '{data: ~d, last: ~l};
  endtask : send
  // Startup clock edges; pin stands still between bursts
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_clk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ext_clk <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : ticks
endmodule : cfg_host_model

// File: verif/config_init_sequencer_tb.sv
`timescale 1ns/1ps
module config_init_sequencer_tb;
  import cfg_init_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic restart_req = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, irq, cfg_valid, cfg_ready, out_valid, load_complete_flag, user_mode, ext_clk;
  logic user_startup_clock_pin_o, user_startup_clock_pin_oe_b, init_done_pin_o, init_done_pin_oe_b;
  logic config_error_status_pin_o, config_error_status_pin_oe_b;
  logic [7:0] out_data;
  cfg_beat_t cfg_beat;
  // Pull-up on status pin
  wire config_error_status_pin_i = config_error_status_pin_oe_b ? 1'b1 : config_error_status_pin_o;
  wire user_startup_clock_pin_i = user_startup_clock_pin_oe_b ? ext_clk : user_startup_clock_pin_o;
  int err_count = 0;
  int checks = 0;
  int cyc_n = 0;
  int n;
  logic [7:0] outs[$];
  always #10 clk_sys = ~clk_sys;
  config_init_sequencer config_init_sequencer_i (.*);
  cfg_host_model cfg_host_model_i (.clk_sys, .cfg_ready, .status_pin(config_error_status_pin_i),
    .cfg_valid, .cfg_beat, .ext_clk);
  always @(posedge clk_sys) begin
    cyc_n++;
    if (out_valid === 1'b1) outs.push_back(out_data);
    if (cyc_n == 60000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rchk
  task automatic go(input logic [31:0] c, input logic [31:0] len);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    wb(1'b1, ADDR_CTRL, c);
    wb(1'b1, ADDR_LENGTH, len);
  endtask : go
  task automatic finish_test;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(ADDR_CTRL, 32'(CTRL_RST));
    rchk(ADDR_LENGTH, 32'(LENGTH_RST));
    rchk(ADDR_IRQ_MASK, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    rchk(ADDR_STATUS, 32'h0000_0011);
    wb(1'b1, ADDR_CTRL, 32'h0000_003a);
    wb(1'b1, ADDR_LENGTH, 32'h0000_0004);
    wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
    chk({user_startup_clock_pin_oe_b, user_startup_clock_pin_o}, 32'h0000_0001);
    cfg_host_model_i.send(8'h55, 1'b0);
    cfg_host_model_i.send(ESC_BYTE, 1'b0);
    cfg_host_model_i.send(8'h02, 1'b1);
    @(posedge clk_sys);
    chk(init_done_pin_oe_b, 32'h0000_0000);
    n = 0;
    while (user_mode !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n > 15900 && n < 15950, 32'h0000_0001);
    chk(outs.size(), 32'h0000_0004);
    chk({outs[0], outs[1], outs[2], outs[3]}, 32'h5500_0000);
    chk(init_done_pin_oe_b, 32'h0000_0001);
    chk(irq, 32'h0000_0001);
    rchk(ADDR_COUNT, {12'(INIT_CYCLES), 4'h0, 16'h0004});
    rchk(ADDR_IRQ_STAT, 32'h0000_0003);
    wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
    @(posedge clk_sys);
    chk(irq, 32'h0000_0000);
    wb(1'b1, ADDR_IRQ_STAT, 32'h0000_0003);
    rchk(ADDR_IRQ_STAT, 32'h0000_0000);
    go(32'h0000_0001, 32'h0000_0001);
    cfg_host_model_i.ticks(3);
    cfg_host_model_i.send(8'ha5, 1'b1);
    repeat (10) @(posedge clk_sys);
    chk({load_complete_flag, init_done_pin_oe_b, user_startup_clock_pin_oe_b}, 32'h0000_0007);
    cfg_host_model_i.ticks(INIT_CYCLES - 1);
    repeat (40) @(posedge clk_sys);
    chk(user_mode, 32'h0000_0000);
    cfg_host_model_i.ticks(1);
    repeat (6) @(posedge clk_sys);
    chk(user_mode, 32'h0000_0001);
    go(32'h0000_0006, 32'h0000_0004);
    cfg_host_model_i.send(8'h11, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk(config_error_status_pin_i, 32'h0000_0000);
    rchk(ADDR_IRQ_STAT, 32'h0000_0004);
    rchk(ADDR_STATUS, 32'h0000_0004);
    n = 0;
    while (config_error_status_pin_i !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n > 1980 && n < 2000, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    rchk(ADDR_STATUS, 32'h0000_0011);
    go(32'h0000_0002, 32'h0000_0004);
    cfg_host_model_i.send(8'h11, 1'b1);
    repeat (2500) @(posedge clk_sys);
    chk(config_error_status_pin_i, 32'h0000_0000);
    restart_req <= 1'b1;
    @(posedge clk_sys);
    restart_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(config_error_status_pin_i, 32'h0000_0001);
    finish_test();
  end
endmodule : config_init_sequencer_tb
bind config_init_sequencer cfg_init_asserts cfg_init_asserts_i (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cfg_ready, .out_valid, .load_complete_flag, .user_mode, .init_done_pin_o, .init_done_pin_oe_b,
  .config_error_status_pin_o, .config_error_status_pin_oe_b);
